/* logic/psc_crc_core.sv */
// Purpose: serial crc accumulator with registered result
// Assumes: caller decides when to seed, shift and capture
// Notes:   one bit per enabled clock, full dot rate
`timescale 1ns/1ns
module psc_crc_core
    import psc_pkg::*;
(
    // clock, reset, enable
    input  wire logic                 i_clk,
    input  wire logic                 i_nrst,
    input  wire logic                 i_ce,
    // control
    input  wire logic                 i_seed,
    input  wire logic                 i_shift,
    input  wire logic                 i_bit,
    // result
    output logic      [PSC_CRC_W-1:0] o_crc
);

    logic [PSC_CRC_W-1:0] crc_r;
    logic [PSC_CRC_W-1:0] crc_nxt;

    always_comb begin
        crc_nxt = crc_r;
        if (i_seed) begin
            crc_nxt = PSC_SEED;
        end else if (i_shift) begin
            crc_nxt = psc_crc_step(crc_r, i_bit);
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            crc_r <= PSC_SEED;
        end else if (i_ce) begin
            crc_r <= crc_nxt;
        end
    end

    assign o_crc = crc_r;

endmodule : psc_crc_core

/* logic/psc_pkg.sv */
// Purpose: shared constants and carriers for the pixel signature block
// Assumes: one dot clock, pixel pipeline on the same clock
// Notes:   crc polynomial is the ccitt x^16+x^12+x^5+1 form
package psc_pkg;

    localparam int          PSC_DATA_W   = 8;
    localparam int          PSC_SEL_W    = 3;
    localparam int          PSC_CRC_W    = 16;
    localparam logic [15:0] PSC_POLY     = 16'h1021;
    localparam logic [15:0] PSC_SEED     = 16'hFFFF;
    localparam logic [15:0] PSC_SIG_RST  = 16'h0000;

    // one pixel beat from the display pipeline
    typedef struct packed {
        logic                  active;
        logic                  frame_start;
        logic                  odd_field;
        logic [PSC_DATA_W-1:0] data;
    } psc_pix_s;

    // result handed to software
    typedef struct packed {
        logic [PSC_CRC_W-1:0] sig;
        logic [PSC_SEL_W-1:0] lane;
    } psc_res_s;

    typedef enum logic [2:0] {
        PSC_IDLE = 3'b001,
        PSC_RUN  = 3'b010,
        PSC_DONE = 3'b100
    } psc_state_e;

    function automatic logic [15:0] psc_crc_step(input logic [15:0] crc,
                                                 input logic        bit_in);
        logic fb;
        fb = crc[15] ^ bit_in;
        psc_crc_step = {crc[14:0], 1'b0} ^ (fb ? PSC_POLY : 16'h0000);
    endfunction : psc_crc_step

endpackage : psc_pkg

/* logic/psc_sig_gen.sv */
// Purpose: per-frame pixel signature generator on the dot clock
// Assumes: pixel beats arrive on i_clk from same-domain logic
// Notes:   an arm request starts a run at the next frame start, the next odd field one when interlaced
// Notes:   an arm given mid run is kept and starts the run after
//
// Behaviour
// - the signature is a 16-bit ccitt crc of the selected stream.
// - only pixels in active display are fed, blanking is skipped.
// - interlaced runs cover an odd field then an even field.
// - one bit lane per pixel feeds the crc serially.
// - a 3-bit lane select, latched once at run start, picks the bit.
// - the crc steps once per pixel at the full dot rate.
`timescale 1ns/1ns
module psc_sig_gen
    import psc_pkg::*;
(
    // clock, reset, enable
    input  wire logic                 i_clk,
    input  wire logic                 i_nrst,
    input  wire logic                 i_ce,
    // control from software side
    input  wire logic                 i_arm,
    input  wire logic [PSC_SEL_W-1:0] i_lane_sel,
    input  wire logic                 i_interlace,
    // pixel stream
    input  wire psc_pix_s             i_pix,
    // result
    output psc_res_s                  o_res,
    output logic                      o_busy,
    output logic                      o_done
);

    psc_state_e           st_r, st_nxt;
    logic [PSC_SEL_W-1:0] lane_r, lane_nxt;
    logic                 arm_r, arm_nxt;
    logic                 odd_seen_r, odd_seen_nxt;
    psc_res_s             res_r, res_nxt;
    logic                 seed, shift, fin;
    logic [PSC_CRC_W-1:0] crc;

    // a run begins only at a frame start; interlace waits for odd field
    logic start_ok;
    assign start_ok = i_pix.frame_start && (!i_interlace || i_pix.odd_field);

    // control group: state, lane, arm request, field tracking
    always_comb begin
        st_nxt       = st_r;
        lane_nxt     = lane_r;
        arm_nxt      = arm_r | i_arm;
        odd_seen_nxt = odd_seen_r;
        seed         = 1'b0;
        shift        = 1'b0;
        fin          = 1'b0;
        unique case (st_r)
            PSC_IDLE, PSC_DONE: begin
                if (arm_r && start_ok) begin
                    st_nxt       = PSC_RUN;
                    lane_nxt     = i_lane_sel;
                    arm_nxt      = 1'b0;
                    odd_seen_nxt = 1'b0;
                    seed         = 1'b1;
                end
            end
            PSC_RUN: begin
                if (i_pix.frame_start) begin
                    // second field still to come when interlaced
                    if (i_interlace && !odd_seen_r) begin
                        odd_seen_nxt = 1'b1;
                    end else begin
                        fin    = 1'b1;
                        st_nxt = PSC_DONE;
                    end
                end
                // every frame start beat is a boundary, never data
                shift = i_pix.active && !i_pix.frame_start;
            end
            default: st_nxt = PSC_IDLE;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            st_r       <= PSC_IDLE;
            lane_r     <= '0;
            arm_r      <= 1'b0;
            odd_seen_r <= 1'b0;
        end else if (i_ce) begin
            st_r       <= st_nxt;
            lane_r     <= lane_nxt;
            arm_r      <= arm_nxt;
            odd_seen_r <= odd_seen_nxt;
        end
    end

    // result group: loaded only on the closing frame start
    always_comb begin
        res_nxt = res_r;
        if (fin) begin
            res_nxt.sig  = crc;
            res_nxt.lane = lane_r;
        end
    end

    // held through done so software may read it late
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            res_r <= '{sig: PSC_SIG_RST, lane: '0};
        end else if (i_ce) begin
            res_r <= res_nxt;
        end
    end

    psc_crc_core i_psc_crc_core (
        .i_clk   (i_clk),
        .i_nrst  (i_nrst),
        .i_ce    (i_ce),
        .i_seed  (seed),
        .i_shift (shift),
        .i_bit   (i_pix.data[lane_r]),
        .o_crc   (crc)
    );

    assign o_res  = res_r;
    assign o_busy = (st_r == PSC_RUN);
    assign o_done = (st_r == PSC_DONE);

    // crc register: seed, step, skip
    AST_SEED_ON_START: assert property (@(posedge i_clk)
        disable iff (!i_nrst)
        i_ce && seed |=> crc == PSC_SEED)
        else $error("crc not seeded at run start");
    AST_BLANK_HOLDS: assert property (@(posedge i_clk)
        disable iff (!i_nrst)
        i_ce && o_busy && !i_pix.active && !i_pix.frame_start
        |=> $stable(crc))
        else $error("crc moved during blanking");
    AST_CRC_STEP: assert property (@(posedge i_clk)
        disable iff (!i_nrst)
        i_ce && shift |=> crc == ({$past(crc[PSC_CRC_W-2:0]), 1'b0}
            ^ (($past(crc[PSC_CRC_W-1]) ^ $past(i_pix.data[lane_r]))
               ? PSC_POLY : 16'h0000)))
        else $error("crc step mismatch");
    AST_BOUNDARY_SKIP: assert property (@(posedge i_clk)
        disable iff (!i_nrst)
        i_ce && o_busy && i_pix.frame_start |=> $stable(crc))
        else $error("frame start beat fed to crc");
    AST_IDLE_HOLDS: assert property (@(posedge i_clk)
        disable iff (!i_nrst)
        i_ce && !o_busy && !seed |=> $stable(crc))
        else $error("crc moved outside a run");

    // lane choice and run framing
    AST_LANE_LATCH: assert property (@(posedge i_clk)
        disable iff (!i_nrst)
        i_ce && seed |=> lane_r == $past(i_lane_sel))
        else $error("lane not latched at start");
    AST_LANE_STABLE: assert property (@(posedge i_clk)
        disable iff (!i_nrst)
        o_busy && $past(o_busy) |-> $stable(lane_r))
        else $error("lane changed mid run");
    AST_START_ALIGN: assert property (@(posedge i_clk)
        disable iff (!i_nrst)
        i_ce && seed
        |-> i_pix.frame_start && (!i_interlace || i_pix.odd_field))
        else $error("run started off a frame start");
    AST_INTERLACE_TWO: assert property (@(posedge i_clk)
        disable iff (!i_nrst)
        i_ce && o_busy && i_interlace && !odd_seen_r && i_pix.frame_start
        |=> o_busy)
        else $error("interlaced run ended after one field");
    AST_ODD_CLEARED: assert property (@(posedge i_clk)
        disable iff (!i_nrst)
        i_ce && seed |=> !odd_seen_r)
        else $error("field tracking not cleared at start");

    // feeding rate and result hand-over
    AST_FULL_RATE: assert property (@(posedge i_clk)
        disable iff (!i_nrst)
        i_ce && o_busy && i_pix.active && !i_pix.frame_start |-> shift)
        else $error("active pixel not fed");
    AST_CLOSE_CAPTURE: assert property (@(posedge i_clk)
        disable iff (!i_nrst)
        i_ce && fin |=> o_done && !o_busy && o_res.sig == $past(crc)
                        && o_res.lane == $past(lane_r))
        else $error("result not captured at close");
    AST_RES_HELD: assert property (@(posedge i_clk)
        disable iff (!i_nrst)
        o_done && $past(o_done) && !$past(seed) |-> $stable(o_res))
        else $error("result not held");
    AST_ARM_KEPT: assert property (@(posedge i_clk)
        disable iff (!i_nrst)
        i_ce && i_arm |=> arm_r || o_busy)
        else $error("arm request lost");
    AST_NO_STRAY_SEED: assert property (@(posedge i_clk)
        disable iff (!i_nrst)
        seed |-> arm_r && !o_busy)
        else $error("seed without a pending arm");

    // enable gating and state sanity
    AST_CE_FREEZE: assert property (@(posedge i_clk)
        disable iff (!i_nrst)
        !i_ce |=> $stable(st_r) && $stable(lane_r) && $stable(arm_r)
                  && $stable(odd_seen_r) && $stable(res_r) && $stable(crc))
        else $error("state moved while clock enable low");
    AST_STATE_ONEHOT: assert property (@(posedge i_clk)
        disable iff (!i_nrst)
        $onehot(st_r))
        else $error("state register not one-hot");
    AST_BUSY_DONE_EXCL: assert property (@(posedge i_clk)
        disable iff (!i_nrst)
        !(o_busy && o_done))
        else $error("busy and done together");

    COV_RUN_DONE: cover property (@(posedge i_clk) o_busy ##1 o_done);
    COV_INTERLACE: cover property (@(posedge i_clk)
        o_busy && i_interlace && odd_seen_r ##1 o_done);
    COV_LANE7: cover property (@(posedge i_clk) seed && i_lane_sel == 3'h7);
    COV_CE_HOLD: cover property (@(posedge i_clk) !i_ce && o_done);
    COV_LANE_MOVED: cover property (@(posedge i_clk)
        o_busy && i_lane_sel != lane_r);

endmodule : psc_sig_gen

/* tb/psc_pix_model.sv */
// Purpose: pixel pipeline model feeding frames to the generator
// Assumes: same dot clock as the generator, clock enable high while frames are fed
// Notes:   logs every active data byte except on the frame start beat, so the bench can rebuild the crc
`timescale 1ns/1ns
module psc_pix_model
    import psc_pkg::*;
(
    // clock
    input  wire logic i_clk,
    // pixel stream
    output psc_pix_s  o_pix
);
    logic [7:0] log_q[$];

    initial o_pix = '0;

    // blanking beats carry junk, so a leak into the crc shows
    task automatic beat(input logic act, input logic fs, input logic odd);
        logic [7:0] d;
        d = 8'($urandom);
        @(posedge i_clk);
        o_pix <= '{active: act, frame_start: fs, odd_field: odd, data: d};
        if (act && !fs) log_q.push_back(d);
    endtask : beat

    // start beat is active on purpose: it must still be skipped
    task automatic frame(input logic odd, input int n);
        beat(1'b1, 1'b1, odd);
        for (int k = 0; k < n; k++) begin
            beat(1'b1, 1'b0, odd);
            if (k % 3 == 2) beat(1'b0, 1'b0, odd);
        end
        beat(1'b0, 1'b0, odd);
    endtask : frame
endmodule : psc_pix_model

/* tb/tb_pixel_signature_crc.sv */
// Purpose: self-checking bench for the pixel signature generator
// Assumes: clock enable high except one frozen edge per run, frames come from the pixel model
// Notes:   expected signatures rebuilt from the logged pixel bytes
`timescale 1ns/1ns
module tb_pixel_signature_crc;
    import psc_pkg::*;
    logic                 i_clk, i_nrst, i_ce, i_arm, i_interlace;
    logic [PSC_SEL_W-1:0] i_lane_sel;
    psc_pix_s             i_pix;
    psc_res_s             o_res, exp_q[$];
    logic                 o_busy, o_done, done_d;
    int                   fail_count, compares, cycles;

    psc_pix_model i_psc_pix_model (.i_clk(i_clk), .o_pix(i_pix));
    psc_sig_gen i_psc_sig_gen (.i_clk(i_clk), .i_nrst(i_nrst), .i_ce(i_ce),
        .i_arm(i_arm), .i_lane_sel(i_lane_sel), .i_interlace(i_interlace),
        .i_pix(i_pix), .o_res(o_res), .o_busy(o_busy), .o_done(o_done));

    always #5 i_clk = ~i_clk;

    function automatic logic [15:0] crc_of(input int lane);
        logic [7:0]  q[$];
        logic [15:0] c;
        q = i_psc_pix_model.log_q;
        c = PSC_SEED;
        foreach (q[k])
            c = {c[14:0], 1'b0} ^ ((c[15] ^ q[k][lane]) ? PSC_POLY : 16'h0);
        return c;
    endfunction : crc_of

    task automatic check_res(input psc_res_s exp, input psc_res_s got);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected o_res exp %h seen %h", exp, got);
        end
    endtask : check_res

    task automatic check_flag(input string name, input logic exp,
                              input logic got);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected %s exp %b seen %b", name, exp, got);
        end
    endtask : check_flag

    task automatic tally_and_finish;
        // a result that never came counts as a miss
        if (exp_q.size() != 0) fail_count++;
        if (fail_count == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : tally_and_finish

    // lane is moved after the first field: only the start value may count
    task automatic run(input logic [2:0] lane, input logic il);
        i_psc_pix_model.log_q.delete();
        @(posedge i_clk);
        i_lane_sel  <= lane;
        i_interlace <= il;
        i_arm       <= 1'b1;
        i_ce        <= 1'b0;
        // frozen edge: the arm has to wait for the enable
        @(posedge i_clk);
        i_ce <= 1'b1;
        @(posedge i_clk);
        i_arm <= 1'b0;
        i_psc_pix_model.frame(1'b1, 7 + lane);
        i_lane_sel <= 3'($urandom);
        @(negedge i_clk);
        check_flag("o_busy", 1'b1, o_busy);
        check_flag("o_done", 1'b0, o_done);
        if (il) begin
            i_psc_pix_model.frame(1'b0, 5);
            @(negedge i_clk);
            check_flag("o_busy", 1'b1, o_busy);
        end
        exp_q.push_back('{sig: crc_of(lane), lane: lane});
        i_psc_pix_model.frame(1'b1, 4);
    endtask : run

    // outputs settle after the rising edge, so look at the falling one
    always @(negedge i_clk) begin
        done_d <= o_done;
        cycles++;
        if (o_done === 1'b1 && done_d !== 1'b1) begin
            check_res(exp_q.size() ? exp_q.pop_front() : 'x, o_res);
            check_flag("o_busy", 1'b0, o_busy);
        end
        if (cycles > 3000) begin
            fail_count++;
            tally_and_finish();
        end
    end

    initial begin
        i_clk       = 1'b0;
        i_nrst      = 1'b0;
        i_ce        = 1'b1;
        i_arm       = 1'b0;
        i_interlace = 1'b0;
        i_lane_sel  = 3'h0;
        void'($urandom(32'h76a2));
        repeat (8) @(posedge i_clk);
        i_nrst <= 1'b1;
        @(negedge i_clk);
        check_res('{sig: PSC_SIG_RST, lane: 3'h0}, o_res);
        check_flag("o_busy", 1'b0, o_busy);
        check_flag("o_done", 1'b0, o_done);
        for (int l = 0; l < 8; l++) run(3'(l), 1'b0);
        run(3'h5, 1'b1);
        run(3'h2, 1'b1);
        repeat (4) @(posedge i_clk);
        tally_and_finish();
    end
endmodule : tb_pixel_signature_crc
